// *** osc_pkg.sv ***
// shared constants of the one-time programmable store and its security word
`default_nettype none
package osc_pkg;
    localparam int SECT_N = 4;
    localparam int ROWS_PER_SECT = 512;
    localparam int ROW_W = 32;
    localparam int OTP_ROWS = SECT_N * ROWS_PER_SECT;
    localparam int OTP_AW = 12;
    localparam int SRAM_AW = 11;
    localparam logic [11:0] SEC_ROW_IDX = 12'h800;
    localparam logic [11:0] LAST_ROW_IDX = 12'h7FF;
    // security word bit positions
    localparam int BIT_JTAG_OFF = 0;
    localparam int BIT_LINK_OFF = 1;
    localparam int BIT_SEC_BOOT = 5;
    localparam int BIT_REDUN = 7;
    localparam int BIT_SLOCK0 = 8;
    localparam int BIT_MLOCK = 12;
    localparam int BIT_JOTP_OFF = 13;
    localparam int BIT_DBG_OFF = 14;
    localparam int GP_LSB = 15;
    localparam int GP_MSB = 21;
    localparam int UID_LSB = 22;
    localparam int UID_MSB = 31;
    localparam logic [31:0] SEC_RST = 32'h0000_0000;
    // internal programming port identities
    localparam logic [23:0] PORT_ID_ADDR = 24'h10_0200;
    localparam logic [23:0] PORT_ID_DATA = 24'h20_0100;
    localparam logic [23:0] PORT_ID_CTRL = 24'h10_0300;
    // register byte offsets
    localparam logic [7:0] OFS_SEC_CFG = 8'h00;
    localparam logic [7:0] OFS_PROG_ADDR = 8'h04;
    localparam logic [7:0] OFS_PROG_DATA = 8'h08;
    localparam logic [7:0] OFS_PROG_CTRL = 8'h0C;
    localparam logic [7:0] OFS_READ_DATA = 8'h10;
    localparam logic [7:0] OFS_USERCODE = 8'h14;
    // control / status bit positions in the control register
    localparam int CTL_PROG = 0;
    localparam int CTL_READ = 1;
    localparam int CTL_SECW = 2;
    localparam int STS_BUSY = 8;
    localparam int STS_REFUSED = 9;
    localparam int STS_DONE = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        REG_SEC, REG_ADDR, REG_DATA, REG_CTRL, REG_RDATA, REG_UCODE, REG_NONE
    } osc_reg_e;
endpackage : osc_pkg
`default_nettype wire

// *** osc_otp_mem.sv ***
// one-time programmable row array with registered read data
`default_nettype none
module osc_otp_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2049,
    parameter int AW = 12
) (
    input wire logic clk,
    input wire logic en,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // blank fuses read as zero; contents survive the logic reset
    initial
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            mem[i] = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (en && wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        if (en && rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : osc_otp_mem
`default_nettype wire

// *** osc_top.sv ***
// security configuration loader, boot copier and programming controller
// Notes on behaviour
// - store is four sectors of 512 rows, 32 bits per row
// - security word is loaded from the store at power-up before it applies
// - remaining store content is copied to tile SRAM and runs first
// - bit 0 set refuses all JTAG access to tile state and memory
// - bit 1 set denies other tiles access to processor state
// - bit 5 set boots the tile from store address 0
// - bit 7 set enables the redundant rows
// - bits 8 to 11 each block programming of sectors 0 to 3
// - bit 12 set rejects all programming, security word included
// - bit 13 set blocks JTAG reads and writes of the store
// - bit 14 set disables the debug synchronisation pin
// - bits 21..15 are a software readable user field
// - bits 31..22 extend the JTAG user code
// - programming address comes through a 16-bit port, id 0x100200
// - programming data comes through a 32-bit port, id 0x200100
// - programming control goes through a 16-bit port, id 0x100300
// - user code reports tile security bits 31..22, zero when blank
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`default_nettype none
module osc_top
    import osc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [15:0] SILICON_REV = 16'h0000  // arbitrary value
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic sram_wr_en,
    output logic [SRAM_AW-1:0] sram_wr_addr,
    output logic [31:0] sram_wr_data,
    output logic proc_release,
    output logic jtag_tile_en,
    output logic link_access_en,
    output logic boot_from_otp,
    output logic redundant_rows_en,
    output logic jtag_otp_en,
    output logic debug_sync_en,
    output logic [GP_MSB-GP_LSB:0] user_field,
    output logic [31:0] usercode
);
    typedef enum logic [3:0] {
        ST_LOAD_RD, ST_LOAD_CAPT, ST_COPY, ST_DRAIN, ST_IDLE,
        ST_PRG_RD, ST_PRG_WR, ST_RD_RD, ST_RD_CAPT
    } osc_state_e;

    function automatic osc_reg_e osc_decode(input logic [ADDR_W-1:0] a);
        osc_reg_e r;
        r = REG_NONE;
        if (a[1:0] == 2'h0)
        begin
            unique case (8'(a))
                OFS_SEC_CFG: r = REG_SEC;
                OFS_PROG_ADDR: r = REG_ADDR;
                OFS_PROG_DATA: r = REG_DATA;
                OFS_PROG_CTRL: r = REG_CTRL;
                OFS_READ_DATA: r = REG_RDATA;
                OFS_USERCODE: r = REG_UCODE;
                default: r = REG_NONE;
            endcase
        end
        return r;
    endfunction : osc_decode

    function automatic logic [31:0] osc_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                m[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return m;
    endfunction : osc_merge

    // bus group
    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d, wdata_q, wdata_d, prog_data_q, prog_data_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [15:0] prog_addr_q, prog_addr_d;
    logic secw_q, secw_d, refused_q, refused_d, done_q, done_d;
    logic prog_go, read_go, do_wr;
    // sequencer group
    osc_state_e state_q, state_d;
    logic [31:0] sec_q, sec_d, read_data_q, read_data_d;
    logic cfg_valid_q, cfg_valid_d, pipe_vld_q, pipe_vld_d;
    logic [OTP_AW-1:0] copy_cnt_q, copy_cnt_d;
    logic [SRAM_AW-1:0] pipe_addr_q, pipe_addr_d;
    logic sram_en_q, sram_en_d, release_q, release_d;
    logic [SRAM_AW-1:0] sram_addr_q, sram_addr_d;
    logic [31:0] sram_data_q, sram_data_d;
    logic [5:0] gate_q, gate_d;
    logic [31:0] ucode_q, ucode_d;
    logic ev_refused, ev_done, mem_rd, mem_wr, op_locked;
    logic [OTP_AW-1:0] mem_rd_addr, op_row;
    logic [31:0] mem_rdata, mem_wdata;

    osc_otp_mem #(.WIDTH(ROW_W), .DEPTH(OTP_ROWS + 1), .AW(OTP_AW)) u_mem (
        .clk(aclk),
        .en(aclk_en),
        .rd_en(mem_rd),
        .rd_addr(mem_rd_addr),
        .wr_en(mem_wr),
        .wr_addr(op_row),
        .wr_data(mem_wdata),
        .rd_data(mem_rdata)
    );

    always_comb
    begin
        awready_d = awready_q;
        wready_d = wready_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        prog_addr_d = prog_addr_q;
        prog_data_d = prog_data_q;
        secw_d = secw_q;
        refused_d = refused_q;
        done_d = done_q;
        prog_go = 1'b0;
        read_go = 1'b0;
        do_wr = !awready_q && !wready_q && !bvalid_q;
        if (s_axi_awvalid && awready_q)
        begin
            awaddr_d = s_axi_awaddr;
            awready_d = 1'b0;
        end
        if (s_axi_wvalid && wready_q)
        begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
            wready_d = 1'b0;
        end
        if (do_wr)
        begin
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            unique case (osc_decode(awaddr_q))
                REG_ADDR: prog_addr_d = 16'(osc_merge({16'h0000, prog_addr_q}, wdata_q,
                                                      wstrb_q));
                REG_DATA: prog_data_d = osc_merge(prog_data_q, wdata_q, wstrb_q);
                REG_CTRL:
                begin
                    if (wstrb_q[0])
                    begin
                        prog_go = wdata_q[CTL_PROG];
                        read_go = wdata_q[CTL_READ] && !wdata_q[CTL_PROG];
                        secw_d = wdata_q[CTL_SECW];
                    end
                    if (wstrb_q[1])
                    begin
                        refused_d = refused_q && !wdata_q[STS_REFUSED];
                        done_d = done_q && !wdata_q[STS_DONE];
                    end
                end
                REG_SEC, REG_RDATA, REG_UCODE: bresp_d = RESP_OKAY;
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        // a completion in the clearing cycle still lands
        if (ev_refused)
        begin
            refused_d = 1'b1;
        end
        if (ev_done)
        begin
            done_d = 1'b1;
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
        if (s_axi_arvalid && arready_q)
        begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            unique case (osc_decode(s_axi_araddr))
                REG_SEC: rdata_d = sec_q;
                REG_ADDR: rdata_d = {16'h0000, prog_addr_q};
                REG_DATA: rdata_d = prog_data_q;
                REG_CTRL: rdata_d = {21'h0, done_q, refused_q, state_q != ST_IDLE,
                                     5'h00, secw_q, 2'h0};
                REG_RDATA: rdata_d = read_data_q;
                REG_UCODE: rdata_d = ucode_q;
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            prog_addr_q <= 16'h0000;
            prog_data_q <= 32'h0000_0000;
            secw_q <= 1'b0;
            refused_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (aclk_en)
        begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            prog_addr_q <= prog_addr_d;
            prog_data_q <= prog_data_d;
            secw_q <= secw_d;
            refused_q <= refused_d;
            done_q <= done_d;
        end
    end

    // sector of a row is its top two address bits; the security row has no sector lock
    assign op_row = secw_q ? SEC_ROW_IDX : {1'b0, prog_addr_q[SRAM_AW-1:0]};
    // the target bit arrives with the go strobe, so the check must see the new value
    assign op_locked = sec_q[BIT_MLOCK]
        || (!secw_d && sec_q[BIT_SLOCK0 + 32'(prog_addr_q[10:9])])
        || (!secw_d && prog_addr_q[15:11] != 5'h00);

    always_comb
    begin
        state_d = state_q;
        sec_d = sec_q;
        cfg_valid_d = cfg_valid_q;
        copy_cnt_d = copy_cnt_q;
        pipe_vld_d = 1'b0;
        pipe_addr_d = pipe_addr_q;
        read_data_d = read_data_q;
        release_d = release_q;
        ev_refused = 1'b0;
        ev_done = 1'b0;
        mem_rd = 1'b0;
        mem_rd_addr = op_row;
        mem_wr = 1'b0;
        mem_wdata = mem_rdata | prog_data_q;  // fuses only ever go from 0 to 1
        unique case (state_q)
            ST_LOAD_RD:
            begin
                mem_rd = 1'b1;
                mem_rd_addr = SEC_ROW_IDX;
                state_d = ST_LOAD_CAPT;
            end
            ST_LOAD_CAPT:
            begin
                sec_d = mem_rdata;
                cfg_valid_d = 1'b1;
                state_d = ST_COPY;
            end
            ST_COPY:
            begin
                mem_rd = 1'b1;
                mem_rd_addr = copy_cnt_q;
                pipe_vld_d = 1'b1;
                pipe_addr_d = copy_cnt_q[SRAM_AW-1:0];
                copy_cnt_d = copy_cnt_q + 12'h001;
                if (copy_cnt_q == LAST_ROW_IDX)
                begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN:
            begin
                if (!pipe_vld_q)
                begin
                    release_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (prog_go && op_locked)
                begin
                    ev_refused = 1'b1;
                end
                else if (prog_go)
                begin
                    state_d = ST_PRG_RD;
                end
                else if (read_go)
                begin
                    state_d = ST_RD_RD;
                end
            end
            ST_PRG_RD:
            begin
                mem_rd = 1'b1;
                state_d = ST_PRG_WR;
            end
            ST_PRG_WR:
            begin
                mem_wr = 1'b1;
                ev_done = 1'b1;
                state_d = ST_IDLE;
            end
            ST_RD_RD:
            begin
                mem_rd = 1'b1;
                state_d = ST_RD_CAPT;
            end
            ST_RD_CAPT:
            begin
                read_data_d = mem_rdata;
                ev_done = 1'b1;
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
        // requests during load, copy or another operation are refused
        if (state_q != ST_IDLE && (prog_go || read_go))
        begin
            ev_refused = 1'b1;
        end
        sram_en_d = pipe_vld_q;
        sram_addr_d = pipe_addr_q;
        sram_data_d = mem_rdata;
        // everything stays shut until the word has been loaded
        gate_d[0] = cfg_valid_q && !sec_q[BIT_JTAG_OFF];
        gate_d[1] = cfg_valid_q && !sec_q[BIT_LINK_OFF];
        gate_d[2] = cfg_valid_q && sec_q[BIT_SEC_BOOT];
        gate_d[3] = cfg_valid_q && sec_q[BIT_REDUN];
        gate_d[4] = cfg_valid_q && !sec_q[BIT_JOTP_OFF] && !sec_q[BIT_JTAG_OFF];
        gate_d[5] = cfg_valid_q && !sec_q[BIT_DBG_OFF];
        ucode_d = {sec_q[UID_MSB:UID_LSB], 6'h00, SILICON_REV};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ST_LOAD_RD;
            sec_q <= SEC_RST;
            cfg_valid_q <= 1'b0;
            copy_cnt_q <= '0;
            pipe_vld_q <= 1'b0;
            pipe_addr_q <= '0;
            read_data_q <= 32'h0000_0000;
            release_q <= 1'b0;
            sram_en_q <= 1'b0;
            sram_addr_q <= '0;
            sram_data_q <= 32'h0000_0000;
            gate_q <= 6'h00;
            ucode_q <= 32'h0000_0000;
        end
        else if (aclk_en)
        begin
            state_q <= state_d;
            sec_q <= sec_d;
            cfg_valid_q <= cfg_valid_d;
            copy_cnt_q <= copy_cnt_d;
            pipe_vld_q <= pipe_vld_d;
            pipe_addr_q <= pipe_addr_d;
            read_data_q <= read_data_d;
            release_q <= release_d;
            sram_en_q <= sram_en_d;
            sram_addr_q <= sram_addr_d;
            sram_data_q <= sram_data_d;
            gate_q <= gate_d;
            ucode_q <= ucode_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign sram_wr_en = sram_en_q;
    assign sram_wr_addr = sram_addr_q;
    assign sram_wr_data = sram_data_q;
    assign proc_release = release_q;
    assign jtag_tile_en = gate_q[0];
    assign link_access_en = gate_q[1];
    assign boot_from_otp = gate_q[2];
    assign redundant_rows_en = gate_q[3];
    assign jtag_otp_en = gate_q[4];
    assign debug_sync_en = gate_q[5];
    assign user_field = sec_q[GP_MSB:GP_LSB];
    assign usercode = ucode_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_JTAG_GATE: assert property ($past(aclk_en) |-> jtag_tile_en ==
        ($past(cfg_valid_q) && !$past(sec_q[BIT_JTAG_OFF]))) else $error("jtag gate wrong");
    AST_LINK_GATE: assert property ($past(aclk_en) && $past(sec_q[BIT_LINK_OFF])
        |-> !link_access_en) else $error("link access open while disabled");
    AST_BOOT_OTP: assert property ($past(aclk_en) |-> boot_from_otp ==
        ($past(cfg_valid_q) && $past(sec_q[BIT_SEC_BOOT]))) else $error("boot source wrong");
    AST_REDUN: assert property ($past(aclk_en) |-> redundant_rows_en ==
        ($past(cfg_valid_q) && $past(sec_q[BIT_REDUN]))) else $error("redundant rows wrong");
    AST_JOTP: assert property ($past(aclk_en) && $past(sec_q[BIT_JOTP_OFF])
        |-> !jtag_otp_en) else $error("jtag store access open");
    AST_DBG: assert property ($past(aclk_en) && $past(sec_q[BIT_DBG_OFF])
        |-> !debug_sync_en) else $error("debug pin open");
    AST_NO_LOCKED_WR: assert property (mem_wr && aclk_en |->
        !sec_q[BIT_MLOCK] && $past(state_q) == ST_PRG_RD) else $error("locked write");
    AST_LOCK_REFUSE: assert property (state_q == ST_IDLE && prog_go && op_locked
        && aclk_en |=> state_q == ST_IDLE && refused_q) else $error("locked op not refused");
    AST_LOAD_FIRST: assert property ($rose(cfg_valid_q) |->
        $past(state_q) == ST_LOAD_CAPT && !proc_release) else $error("load order wrong");
    AST_RELEASE: assert property ($rose(proc_release) |->
        cfg_valid_q && $past(sram_wr_en)) else $error("release before copy ended");
    AST_USERCODE: assert property ($past(aclk_en) |-> usercode[31:22] ==
        $past(sec_q[UID_MSB:UID_LSB])) else $error("usercode field wrong");
endmodule : osc_top
`default_nettype wire

// *** osc_host.sv ***
// register-bus master standing in for the tile processor
`default_nettype none
module osc_host
    import osc_pkg::*;
(
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // an edge passes before each request so a ready is never lowered and raised at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : osc_host
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the security word and store programming
`default_nettype none
module testbench
    import osc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, sram_wr_data, usercode, row_exp;
    logic [1:0] rresp, bresp;
    logic [10:0] sram_wr_addr;
    logic [6:0] user_field;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sram_wr_en, proc_release;
    wire [5:0] gates;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int copies = 0;
    always #2 aclk = ~aclk;
    osc_top osc_top_inst (.aclk(aclk), .aresetn(aresetn), .aclk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sram_wr_en(sram_wr_en), .sram_wr_addr(sram_wr_addr), .sram_wr_data(sram_wr_data),
        .proc_release(proc_release), .jtag_tile_en(gates[5]), .link_access_en(gates[4]),
        .boot_from_otp(gates[3]), .redundant_rows_en(gates[2]), .jtag_otp_en(gates[1]),
        .debug_sync_en(gates[0]), .user_field(user_field), .usercode(usercode));
    osc_host osc_host_inst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic done_test(input string name);
        $display("test %s ended, checks %0d", name, num_checks);
    endtask : done_test
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    // reset, wait for the boot copy, then compare every gate with the word
    task automatic boot(input logic [31:0] s);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // freeze the copy briefly: no row may be skipped or sent twice
        repeat (100) @(posedge aclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge aclk);
        clk_en <= 1'b1;
        n = 0;
        while (proc_release !== 1'b1 && n < 3000)
        begin
            @(posedge aclk);
            n++;
        end
        @(posedge aclk);
        chk(copies, 2048, "rows copied");
        chk({26'h0, gates}, {26'h0, ~s[0], ~s[1], s[5], s[7], ~(s[13] | s[0]), ~s[14]},
            "gates");
        chk({25'h0, user_field}, {25'h0, s[21:15]}, "user field");
        osc_host_inst.rd(OFS_SEC_CFG, d, r);
        chk(d, s, "sec word");
        osc_host_inst.rd(OFS_USERCODE, d, r);
        chk(d, {s[31:22], 22'h0}, "usercode");
    endtask : boot
    // status polling is bounded so a stuck busy flag cannot hang the run
    task automatic op(input logic [31:0] c, input logic [15:0] a, input logic [31:0] dat,
        output logic [31:0] s);
        logic [1:0] r;
        int n;
        osc_host_inst.wr(OFS_PROG_ADDR, {16'h0, a});
        osc_host_inst.wr(OFS_PROG_DATA, dat);
        osc_host_inst.wr(OFS_PROG_CTRL, c);
        n = 0;
        s = '0;
        while (s[STS_DONE] !== 1'b1 && s[STS_REFUSED] !== 1'b1 && n < 50)
        begin
            osc_host_inst.rd(OFS_PROG_CTRL, s, r);
            n++;
        end
        osc_host_inst.wr(OFS_PROG_CTRL, 32'h0000_0600);
    endtask : op
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            finish_test();
        end
        if (!aresetn)
            copies = 0;
        else if (sram_wr_en === 1'b1 && clk_en)
        begin
            chk({21'h0, sram_wr_addr}, copies, "copy addr");
            if (sram_wr_addr == 11'h200)
                chk(sram_wr_data, row_exp, "copy data");
            copies++;
        end
        // every write of this bench targets a mapped register
        if (bvalid === 1'b1 && bready === 1'b1)
            chk({30'h0, bresp}, {30'h0, RESP_OKAY}, "write response");
    end
    initial
    begin
        logic [31:0] d;
        logic [31:0] s;
        logic [1:0] r;
        row_exp = 32'h0;
        boot(32'h0);
        osc_host_inst.rd(8'h18, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped");
        done_test("blank");
        op(32'h1, 16'h0200, 32'hA5A5_0F0F, s);
        chk(s & 32'h600, 32'h400, "prog done");
        op(32'h1, 16'h0200, 32'h0000_F000, s);
        row_exp = 32'hA5A5_FF0F;
        op(32'h2, 16'h0200, 32'h0, s);
        osc_host_inst.rd(OFS_READ_DATA, d, r);
        chk(d, row_exp, "row read");
        op(32'h5, 16'h0, 32'hAAEA_E2A3, s);
        osc_host_inst.rd(OFS_SEC_CFG, d, r);
        chk(d, 32'h0, "word before reset");
        done_test("program");
        boot(32'hAAEA_E2A3);
        op(32'h1, 16'h0200, 32'hFFFF_FFFF, s);
        chk(s & 32'h600, 32'h200, "sector lock");
        op(32'h2, 16'h0200, 32'h0, s);
        osc_host_inst.rd(OFS_READ_DATA, d, r);
        chk(d, row_exp, "locked row");
        op(32'h1, 16'h0000, 32'h0000_0001, s);
        chk(s & 32'h600, 32'h400, "open sector");
        op(32'h5, 16'h0, 32'h0000_1000, s);
        done_test("sector lock");
        boot(32'hAAEA_F2A3);
        op(32'h1, 16'h0000, 32'h0000_0002, s);
        chk(s & 32'h600, 32'h200, "master lock");
        op(32'h5, 16'h0, 32'h0000_0100, s);
        chk(s & 32'h600, 32'h200, "word lock");
        op(32'h2, 16'h0000, 32'h0, s);
        osc_host_inst.rd(OFS_READ_DATA, d, r);
        chk(d, 32'h0000_0001, "row kept");
        done_test("master lock");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
